// [verilog/fpc_top.sv]
// flash program/erase control and status logic with a wishbone register slave
// assumes synchronous inputs, the cpu core reporting its events and a download engine
// Function
// - registers are eight bits, byte accessed
// - reset or hardware standby restores initial values
// - bit 7 mirrors enable pin level
// - bits 6,5,2,1 reserved, writable, reset zero
// - error flag blocks further program/erase
// - interrupt during program/erase sets error
// - flash read during program/erase sets error
// - sleep or standby during program/erase sets error
// - foreign bus master during program/erase sets error
// - error stays until reset or standby
// - remap bit redirects low vectors to ram
// - remap clear uses normal vector table
// - download request write-only, keyed, self-clearing
//
// register map, one byte in bits 7:0 of each aligned word:
//   offset 0x0  control/status {pin mirror, res, res, error, remap, res, res, download}
//   offset 0x4  key code, compared with the key value on a download request
//   offset 0x8  interrupt status, bit 0 error, bit 1 download done, write one to clear
//   offset 0xc  interrupt mask, same layout as the status
//   other offsets read zero, take writes silently and still ack
// bus timing:
//   ack is registered, one cycle after the request, and lasts one cycle
//   writes land on the edge that takes the request, read data stands with ack
//   only byte lane 0 is written; the upper lanes read zero
// hazards and limits:
//   the error flag has no software clear, only reset or standby end error protection
//   the long reset hold after an error belongs to the reset controller, shown on error_reset_req_o
//   a hardware event wins over a write-one-to-clear in the same cycle, so no event is lost
//   the error interrupt fires only when the flag first sets, later faults add nothing
//   remapped fetches keep the low seven address bits only, vectors above 31 land wrongly
//   vector addresses pass through a register, so every fetch address is one cycle late
//   the download request never reads back as one; completion shows as bit 1 of the interrupt status
//   a second download request while one runs is ignored
//   the pin mirror is live, not latched, so a read shows the level at the read
//   fault inputs are levels and count only while pe_busy_i is high
//   reserved bits are plain storage; software is expected to keep them zero
//   hardware standby acts exactly like reset on every register
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_top
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             hw_standby_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [`FPC_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // cpu and flash events
    input  wire logic             pe_enable_pin_i,
    input  wire logic             pe_busy_i,
    input  wire logic             irq_taken_i,
    input  wire logic             flash_read_i,
    input  wire logic             sleep_i,
    input  wire logic             foreign_master_i,
    input  wire logic             exec_in_ram_i,
    input  wire logic             dl_done_i,
    // vector fetch remap
    input  wire logic             vec_fetch_i,
    input  wire fpc_pkg::fpc_addr_t vec_addr_i,
    output fpc_pkg::fpc_addr_t    vec_addr_o,
    // flash control outputs
    output logic                  pe_allow_o,
    output logic                  dl_start_o,
    output logic                  error_reset_req_o,
    output logic                  irq_o
);
    import fpc_pkg::*;

    // bus decode and write strobes
    logic          init;
    logic          bus_req;
    logic          wr_byte0;
    logic          wr_ctrl;
    logic          wr_key;
    logic          wr_status;
    logic          wr_mask;
    logic [31:0]   next_rdata;

    // control byte and key state
    fpc_byte_t     ctrl_rd;
    logic          pe_error_flag;
    logic          vector_remap_enable;
    logic [1:0]    reserved_hi;
    logic [1:0]    reserved_lo;
    fpc_byte_t     key_code_register;

    // fault sources and download sequencing
    logic          fault_irq;
    logic          fault_read;
    logic          fault_sleep;
    logic          fault_master;
    logic          err_event;
    logic          dl_req_ok;
    fpc_dl_state_t dl_state;

    // interrupt state
    logic [`FPC_IRQ_W-1:0] irq_status;
    logic [`FPC_IRQ_W-1:0] irq_mask;
    logic [`FPC_IRQ_W-1:0] irq_event;

    // vector remap decode
    logic          vec_low;

    // system reset and hardware standby both initialise
    assign init     = rst_i | hw_standby_i;

    // a request is taken while it is not yet answered
    assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // only byte lane 0 carries register data
    assign wr_byte0 = bus_req & wb_we_i & wb_sel_i[0];

    // one write strobe per register, unmapped offsets write nothing
    assign wr_ctrl   = wr_byte0 & (wb_adr_i == `FPC_OFF_CTRL);
    assign wr_key    = wr_byte0 & (wb_adr_i == `FPC_OFF_KEY);
    assign wr_status = wr_byte0 & (wb_adr_i == `FPC_OFF_IRQ_STATUS);
    assign wr_mask   = wr_byte0 & (wb_adr_i == `FPC_OFF_IRQ_MASK);

    // each fault counts only while program/erase runs
    assign fault_irq    = pe_busy_i & irq_taken_i;
    assign fault_read   = pe_busy_i & flash_read_i;
    assign fault_sleep  = pe_busy_i & sleep_i;
    assign fault_master = pe_busy_i & foreign_master_i;

    // any fault during program/erase
    assign err_event = fault_irq | fault_read | fault_sleep | fault_master;

    // download request accepted only with key and from ram
    assign dl_req_ok = wr_ctrl && wb_dat_i[`FPC_BIT_DL]
                     && (key_code_register == `FPC_KEY_VALUE) && exec_in_ram_i;

    // wishbone ack, one cycle per request
    always_ff @(posedge clk_i)
    begin
        if (init)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req;
    end

    // sticky error flag, set only by hardware events
    always_ff @(posedge clk_i)
    begin
        if (init)
            pe_error_flag <= 1'b0;
        else if (err_event)
            pe_error_flag <= 1'b1;
    end

    // remap control bit of the status byte
    always_ff @(posedge clk_i)
    begin
        if (init)
            vector_remap_enable <= 1'b0;
        else if (wr_ctrl)
            vector_remap_enable <= wb_dat_i[`FPC_BIT_REMAP];
    end

    // reserved bits are plain storage, reset to zero
    always_ff @(posedge clk_i)
    begin
        if (init)
        begin
            reserved_hi <= `FPC_PAIR_RESET;
            reserved_lo <= `FPC_PAIR_RESET;
        end
        else if (wr_ctrl)
        begin
            reserved_hi <= wb_dat_i[`FPC_BIT_RES6:`FPC_BIT_RES5];
            reserved_lo <= wb_dat_i[`FPC_BIT_RES2:`FPC_BIT_RES1];
        end
    end

    // key register
    always_ff @(posedge clk_i)
    begin
        if (init)
            key_code_register <= `FPC_RESET_BYTE;
        else if (wr_key)
            key_code_register <= wb_dat_i[`FPC_BYTE_MSB:0];
    end

    // download sequencer, request self-clears on completion
    always_ff @(posedge clk_i)
    begin
        if (init)
            dl_state <= FPC_DL_IDLE;
        else
        begin
            unique case (dl_state)
                FPC_DL_IDLE:
                    if (dl_req_ok)
                        dl_state <= FPC_DL_BUSY;
                FPC_DL_BUSY:
                    if (dl_done_i)
                        dl_state <= FPC_DL_IDLE;
            endcase
        end
    end

    // one-cycle download start pulse
    always_ff @(posedge clk_i)
    begin
        if (init)
            dl_start_o <= 1'b0;
        else
            dl_start_o <= dl_req_ok && (dl_state == FPC_DL_IDLE);
    end

    // interrupt events, set wins over write-one-to-clear
    assign irq_event = {dl_done_i && (dl_state == FPC_DL_BUSY), err_event && !pe_error_flag};

    // sticky status bits, cleared by writing ones
    always_ff @(posedge clk_i)
    begin
        if (init)
            irq_status <= `FPC_IRQ_RESET;
        else if (wr_status)
            irq_status <= (irq_status & ~wb_dat_i[`FPC_IRQ_W-1:0]) | irq_event;
        else
            irq_status <= irq_status | irq_event;
    end

    // interrupt mask
    always_ff @(posedge clk_i)
    begin
        if (init)
            irq_mask <= `FPC_IRQ_RESET;
        else if (wr_mask)
            irq_mask <= wb_dat_i[`FPC_IRQ_W-1:0];
    end

    // status byte, pin mirror live, download bit reads zero
    always_comb
    begin
        ctrl_rd                  = `FPC_RESET_BYTE;
        ctrl_rd[`FPC_BIT_PIN]    = pe_enable_pin_i;
        ctrl_rd[`FPC_BIT_RES6:`FPC_BIT_RES5] = reserved_hi;
        ctrl_rd[`FPC_BIT_ERR]    = pe_error_flag;
        ctrl_rd[`FPC_BIT_REMAP]  = vector_remap_enable;
        ctrl_rd[`FPC_BIT_RES2:`FPC_BIT_RES1] = reserved_lo;
        ctrl_rd[`FPC_BIT_DL]     = 1'b0;
    end

    // read mux, unmapped offsets read zero
    always_comb
    begin
        next_rdata = `FPC_WORD_RESET;
        unique case (wb_adr_i)
            `FPC_OFF_CTRL:       next_rdata = {24'h0, ctrl_rd};
            `FPC_OFF_KEY:        next_rdata = {24'h0, key_code_register};
            `FPC_OFF_IRQ_STATUS: next_rdata = {30'h0, irq_status};
            `FPC_OFF_IRQ_MASK:   next_rdata = {30'h0, irq_mask};
            default:             next_rdata = `FPC_WORD_RESET;
        endcase
    end

    // registered read data
    always_ff @(posedge clk_i)
    begin
        if (init)
            wb_dat_o <= `FPC_WORD_RESET;
        else if (bus_req && !wb_we_i)
            wb_dat_o <= next_rdata;
    end

    // a fetch inside the low table is remapped while the bit is set
    assign vec_low = vec_fetch_i && vector_remap_enable && (vec_addr_i <= `FPC_VEC_LOW_LAST);

    // vector fetch address, low vectors go to ram when remapped
    always_ff @(posedge clk_i)
    begin
        if (init)
            vec_addr_o <= `FPC_VEC_RESET;
        else if (vec_low)
            vec_addr_o <= `FPC_RAM_VEC_BASE | (vec_addr_i & `FPC_VEC_OFS_MASK);
        else
            vec_addr_o <= vec_addr_i;
    end

    // error protection and long reset request
    assign pe_allow_o        = pe_enable_pin_i & ~pe_error_flag;
    assign error_reset_req_o = pe_error_flag;

    // level interrupt while any unmasked status bit is set
    assign irq_o             = |(irq_status & irq_mask);
endmodule : fpc_top
`default_nettype wire

// [include/fpc_regs.svh]
// register offsets, field positions and reset values of the flash program/erase control block
// assumes a wishbone bus with 32-bit data, one aligned word per register
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_ADDR_W          4
`define FPC_OFF_CTRL        4'h0
`define FPC_OFF_KEY         4'h4
`define FPC_OFF_IRQ_STATUS  4'h8
`define FPC_OFF_IRQ_MASK    4'hc
`define FPC_BIT_PIN         7
`define FPC_BIT_RES6        6
`define FPC_BIT_RES5        5
`define FPC_BIT_ERR         4
`define FPC_BIT_REMAP       3
`define FPC_BIT_RES2        2
`define FPC_BIT_RES1        1
`define FPC_BIT_DL          0
`define FPC_KEY_VALUE       8'ha5
`define FPC_RESET_BYTE      8'h00
`define FPC_BYTE_MSB        7
`define FPC_WORD_RESET      32'h00000000
`define FPC_VEC_RESET       24'h000000
`define FPC_PAIR_RESET      2'h0
`define FPC_RAM_VEC_BASE    24'hff8000
`define FPC_VEC_LOW_LAST    24'h00017f
`define FPC_VEC_OFS_MASK    24'h00007f
`define FPC_IRQ_ERR         0
`define FPC_IRQ_DL_DONE     1
`define FPC_IRQ_W           2
`define FPC_IRQ_RESET       2'h0
`endif

// [include/fpc_pkg.sv]
// types for the flash program/erase control block
// assumes the register header is included alongside
package fpc_pkg;
    typedef logic [7:0]  fpc_byte_t;
    typedef logic [23:0] fpc_addr_t;
    typedef enum logic [1:0] {
        FPC_DL_IDLE = 2'b01,
        FPC_DL_BUSY = 2'b10
    } fpc_dl_state_t;
endpackage : fpc_pkg

// [testbench/fpc_top_props.sv]
// checker of the flash program/erase control block, bound to its top module
// assumes one clock with synchronous reset and standby
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_top_props
(
    // clock, reset and bus
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   hw_standby_i,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic                   wb_ack_o,
    input wire logic [`FPC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]             wb_sel_i,
    input wire logic [31:0]            wb_dat_i,
    input wire logic [31:0]            wb_dat_o,
    // cpu events and flash control
    input wire logic                   pe_enable_pin_i,
    input wire logic                   pe_busy_i,
    input wire logic                   irq_taken_i,
    input wire logic                   flash_read_i,
    input wire logic                   sleep_i,
    input wire logic                   foreign_master_i,
    input wire logic                   vec_fetch_i,
    input wire logic                   pe_allow_o,
    input wire logic                   error_reset_req_o,
    input wire logic                   irq_o,
    input wire fpc_pkg::fpc_addr_t     vec_addr_i,
    input wire fpc_pkg::fpc_addr_t     vec_addr_o
);
    logic remap_seen;
    // remap bit as last written, taken on the edge that takes the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i || hw_standby_i)
            remap_seen <= 1'b0;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `FPC_OFF_CTRL)
            remap_seen <= wb_dat_i[`FPC_BIT_REMAP];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || hw_standby_i);
    // request, fault and control read steps
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_fault; pe_busy_i && (irq_taken_i || flash_read_i || sleep_i || foreign_master_i); endsequence
    sequence s_rd_ctrl; wb_ack_o && !wb_we_i && wb_adr_i == `FPC_OFF_CTRL; endsequence
    a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
    a_ctrl_read: assert property (s_rd_ctrl |-> wb_dat_o[7] == $past(pe_enable_pin_i) && !wb_dat_o[0])
        else $error("ctrl read bits");
    a_error_sets: assert property (s_fault |-> ##[1:2] error_reset_req_o) else $error("error not set");
    a_error_sticky: assert property (error_reset_req_o |=> error_reset_req_o) else $error("error dropped");
    a_allow_block: assert property (pe_allow_o == (pe_enable_pin_i && !error_reset_req_o)) else $error("allow");
    a_reset_clears: assert property (disable iff (1'b0) rst_i || hw_standby_i |=> !wb_ack_o && !error_reset_req_o && !irq_o)
        else $error("reset state");
    a_vec_pass: assert property (vec_fetch_i && vec_addr_i > `FPC_VEC_LOW_LAST |=> vec_addr_o == $past(vec_addr_i))
        else $error("high vector moved");
    a_vec_low: assert property (vec_fetch_i && vec_addr_i <= `FPC_VEC_LOW_LAST |=> vec_addr_o ==
        ($past(remap_seen) ? (`FPC_RAM_VEC_BASE | ($past(vec_addr_i) & `FPC_VEC_OFS_MASK)) : $past(vec_addr_i)))
        else $error("vector map");
endmodule : fpc_top_props
bind fpc_top fpc_top_props chk_u (.*);
`default_nettype wire

// [testbench/fpc_cpu_model.sv]
// cpu model running one program/erase pass from ram, committing faults on command
// assumes go_i pulses for one cycle; fault_i picks the events to raise
`timescale 1ns/1ps
`default_nettype none
module fpc_cpu_model
(
    // clock, reset and command
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [3:0] fault_i,
    // busy and event lines
    output logic            busy_o,
    output logic [3:0]      ev_o
);
    logic [2:0] cnt;
    // four cycle busy window after go
    always_ff @(posedge clk_i)
    begin
        if (rst_i) cnt <= 3'h0;
        else if (go_i) cnt <= 3'h4;
        else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    end
    assign busy_o = (cnt != 3'h0);
    // events only when commanded; interrupts otherwise stay masked
    assign ev_o = busy_o ? ((cnt == 3'h2) ? fault_i : 4'h0) : fault_i;
endmodule : fpc_cpu_model
`default_nettype wire

// [testbench/fpc_top_bench.sv]
// bench for the flash program/erase control block over wishbone
// assumes the design, the cpu model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module fpc_top_bench;
    import fpc_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, stdby = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        pin = 1'b1, ram = 1'b0, done = 1'b0, vf = 1'b0, go = 1'b0, ack, allow, dls, err, irq, busy;
    logic [3:0]  adr = 4'h0, fault = 4'h0, ev;
    logic [31:0] wdat = 32'h0, dat_o, q;
    fpc_addr_t   va = 24'h0, vo;
    int          num_errors = 0, cmp_count = 0, cycles = 0, dl_cnt = 0;
    localparam int ERR_HOLD   = 10000; // 100 us of reset at 10 ns a cycle
    localparam int MAX_CYCLES = 50000; // four long reset holds plus the short tests
    fpc_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .fault_i(fault), .busy_o(busy), .ev_o(ev));
    fpc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(stdby), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pe_enable_pin_i(pin), .pe_busy_i(busy), .irq_taken_i(ev[0]), .flash_read_i(ev[1]), .sleep_i(ev[2]),
        .foreign_master_i(ev[3]), .exec_in_ram_i(ram), .dl_done_i(done), .vec_fetch_i(vf), .vec_addr_i(va),
        .vec_addr_o(vo), .pe_allow_o(allow), .dl_start_o(dls), .error_reset_req_o(err), .irq_o(irq));
    initial forever #5 clk_i = ~clk_i;
    // timeout and download start counting
    always @(posedge clk_i)
    begin
        cycles++;
        if (dls === 1'b1) dl_cnt++;
        if (cycles == MAX_CYCLES)
        begin
            num_errors++;
            results();
        end
    end
    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        bus(1'b0, a, 8'h00);
        chk(n, {24'h0, e}, q);
    endtask : rd
    task automatic rst(input logic s);
        @(posedge clk_i);
        if (s) stdby <= 1'b1; else rst_i <= 1'b1;
        // after an error the reset controller holds the long reset
        repeat ((err === 1'b1) ? ERR_HOLD : 2) @(posedge clk_i);
        stdby <= 1'b0;
        rst_i <= 1'b0;
    endtask : rst
    task automatic vec(input fpc_addr_t a, input fpc_addr_t e);
        @(posedge clk_i);
        vf <= 1'b1;
        va <= a;
        @(posedge clk_i);
        vf <= 1'b0;
        @(posedge clk_i);
        chk("vector", {8'h0, e}, {8'h0, vo});
    endtask : vec
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 8'h80, "ctrl reset");
        wr(4'h0, 8'h99);
        rd(4'h0, 8'h88, "ctrl bits");
        pin <= 1'b0;
        rd(4'h0, 8'h08, "ctrl pin low");
        chk("allow pin low", 32'h0, {31'h0, allow});
        rd(4'h2, 8'h00, "unmapped");
        pin <= 1'b1;
        // the ram vector table is taken as filled before remap is set
        wr(4'h0, 8'h08);
        vec(24'h000010, 24'hff8010);
        vec(24'h00017f, 24'hff807f);
        vec(24'h000180, 24'h000180);
        wr(4'h0, 8'h00);
        vec(24'h000010, 24'h000010);
        wr(4'hc, 8'h03);
        wr(4'h4, 8'h00);
        ram <= 1'b1;
        wr(4'h0, 8'h01);
        wr(4'h4, 8'ha5);
        ram <= 1'b0;
        wr(4'h0, 8'h01);
        chk("keyless start", 32'h0, 32'(dl_cnt));
        ram <= 1'b1;
        wr(4'h0, 8'h01);
        repeat (3) @(posedge clk_i);
        chk("download start", 32'h1, 32'(dl_cnt));
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        rd(4'h8, 8'h02, "status done");
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(4'h8, 8'h02);
        @(posedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        fault <= 4'hf;
        repeat (3) @(posedge clk_i);
        fault <= 4'h0;
        rd(4'h0, 8'h80, "idle events");
        for (int i = 0; i < 4; i++)
        begin
            rst(i[0]);
            fault <= 4'(1 << i);
            go <= 1'b1;
            @(posedge clk_i);
            go <= 1'b0;
            repeat (8) @(posedge clk_i);
            fault <= 4'h0;
            wr(4'h0, 8'h00);
            rd(4'h0, 8'h90, "error flag");
            chk("allow after error", 32'h0, {31'h0, allow});
            chk("reset request", 32'h1, {31'h0, err});
            rd(4'h8, 8'h01, "status error");
        end
        rst(1'b0);
        rd(4'h0, 8'h80, "error cleared");
        chk("reset request cleared", 32'h0, {31'h0, err});
        results();
    end
endmodule : fpc_top_bench
`default_nettype wire
